// >>> verilog/lor_consts.svh
// Purpose: Constants of the logic output router (offsets, resets, codes, timing)
// Assumes: 125 MHz scan clock, 32-bit AHB-Lite register window
// Notes:   Included by the package and the router module
//
// Overview of operation
// RULE1: Steps numbered 1 to 200 individually
// RULE2: Only ten routed outputs reach outside functions
// RULE3: Internal input selector takes any step result
// RULE4: Source 0 disabled, 1..200 pick step
// RULE5: Digital function codes as general input set
// RULE6: Codes 8001/8002/8004 speed, reversible speed, torque
// RULE7: Function selectors default to 100
// RULE8: Routed output drives named sequence input
// RULE9: Routed output drives named analog command
// RULE10: Digital terminal shows routed output it names
// RULE11: Analog terminal shows routed output it names
// RULE12: Digital terminals refresh only every 5 ms
// RULE13: Disabled routed output drives inactive zero
// RULE14: Terminals sample per tick, hold till next; the analog terminal updates every cycle instead
`ifndef LOR_CONSTS_SVH
`define LOR_CONSTS_SVH
// Sizes
`define LOR_NUM_STEPS     200
`define LOR_NUM_OUT       10
`define LOR_NUM_DTERM     3
`define LOR_DIG_CODES     100
// Register byte offsets
`define LOR_SRC_BASE      8'h00
`define LOR_FUNC_BASE     8'h28
`define LOR_DTERM_BASE    8'h50
`define LOR_ATERM_OFS     8'h5c
`define LOR_FEED_OFS      8'h60
`define LOR_STATUS_OFS    8'h64
// Reset values
`define LOR_SRC_RST       8'h00
`define LOR_FUNC_RST      16'h0064
`define LOR_TERM_RST      4'h0
// Function codes
`define LOR_DIG_NONE      16'h0064
`define LOR_DIG_NEG_BASE  16'h03e8
`define LOR_DIG_NEG_END   16'h044c
`define LOR_ANA_SPEED     16'h1f41
`define LOR_ANA_SPEED_REV 16'h1f42
`define LOR_ANA_TORQUE    16'h1f44
// Timing
`define LOR_CLK_PERIOD_NS 8
`define LOR_REFRESH_NS    5000000
`endif

// >>> verilog/lor_pkg.sv
// Purpose: Types of the logic output router
// Assumes: lor_consts.svh supplies all sizes
// Notes:   The whole router state is one packed struct
`include "lor_consts.svh"
package lor_pkg;
    typedef logic [15:0] lor_ana_t;                        // Analog step value
    typedef struct packed {
        lor_ana_t speed;                                   // Speed command, non-reversible
        lor_ana_t speed_rev;                               // Speed command, reversible
        lor_ana_t torque;                                  // Torque bias command
    } lor_cmd_t;
    typedef struct packed {
        logic [`LOR_NUM_OUT-1:0][7:0]     src;             // Output-source selectors
        logic [`LOR_NUM_OUT-1:0][15:0]    func;            // Function selectors
        logic [`LOR_NUM_DTERM-1:0][3:0]   dterm_sel;       // Digital terminal assignments
        logic [3:0]                       aterm_sel;       // Analog terminal assignment
        logic [7:0]                       feed_sel;        // Internal input selector
        logic                             wr_pend;         // Write data phase pending
        logic [7:0]                       wr_addr;         // Latched write offset
        logic                             hready;          // Bus ready
        logic                             hresp;           // Bus response
        logic [31:0]                      hrdata;          // Bus read data
        logic [19:0]                      tick_cnt;        // Refresh counter
        logic [`LOR_NUM_OUT-1:0]          route_dig;       // Routed digital values
        logic [`LOR_NUM_OUT-1:0][15:0]    route_ana;       // Routed analog values
        logic [`LOR_NUM_DTERM-1:0]        dterm;           // Digital terminal levels
        lor_ana_t                         aterm;           // Analog terminal value
        logic [`LOR_DIG_CODES-1:0]        seq_func;        // Sequence input functions
        lor_cmd_t                         cmd;             // Analog commands
        logic                             feed_dig;        // Feedback digital value
        lor_ana_t                         feed_ana;        // Feedback analog value
    } lor_state_t;
endpackage

// >>> verilog/lor_router.sv
// Purpose: Routes step results to ten routed outputs and binds them to functions
// Assumes: Step results come from logic on the same clock; AHB-Lite slave, zero wait
// Notes:   All outputs are registered fields of one state struct
`timescale 1ns/10ps
`include "lor_consts.svh"
module lor_router #(
    parameter int REFRESH_CYCLES = `LOR_REFRESH_NS / `LOR_CLK_PERIOD_NS  // Terminal refresh period
) (
    input  wire logic                                         i_clk,        // Scan clock
    input  wire logic                                         i_rstn,       // Sync reset, active low
    input  wire logic                                         i_hsel,       // Slave select
    input  wire logic [31:0]                                  i_haddr,      // Byte address
    input  wire logic [1:0]                                   i_htrans,     // Transfer type
    input  wire logic                                         i_hwrite,     // Write when high
    input  wire logic [2:0]                                   i_hsize,      // Transfer size
    input  wire logic [31:0]                                  i_hwdata,     // Write data
    input  wire logic                                         i_hready,     // Bus ready in
    output logic                                              o_hreadyout,  // Slave ready
    output logic                                              o_hresp,      // Always OKAY
    output logic [31:0]                                       o_hrdata,     // Read data
    input  wire logic [`LOR_NUM_STEPS-1:0]                    i_step_dig,   // Digital step results
    input  wire lor_pkg::lor_ana_t [`LOR_NUM_STEPS-1:0]       i_step_ana,   // Analog step results
    output logic [`LOR_NUM_OUT-1:0]                           o_route_dig,  // Routed digital outputs
    output lor_pkg::lor_ana_t [`LOR_NUM_OUT-1:0]              o_route_ana,  // Routed analog outputs
    output logic [`LOR_DIG_CODES-1:0]                         o_seq_func,   // Sequence input functions
    output lor_pkg::lor_cmd_t                                 o_cmd,        // Analog commands
    output logic [`LOR_NUM_DTERM-1:0]                         o_dterm,      // Digital terminals
    output lor_pkg::lor_ana_t                                 o_aterm,      // Analog terminal
    output logic                                              o_feed_dig,   // Internal feedback, digital
    output lor_pkg::lor_ana_t                                 o_feed_ana    // Internal feedback, analog
);
    import lor_pkg::*;

    lor_state_t st_ff;                                     // Registered state
    lor_state_t nxt_st;                                    // Next state

    // Picks a digital step result; 0 or out of range gives zero
    function automatic logic pick_dig(input logic [7:0] sel, input logic [`LOR_NUM_STEPS-1:0] steps);
        logic r;
        r = 1'b0;
        if (sel != 8'h00 && sel <= 8'(`LOR_NUM_STEPS)) begin
            r = steps[sel - 8'h01];                        // Step n sits at index n-1 [RULE1] [RULE4]
        end
        return r;
    endfunction

    // Picks an analog step result; 0 or out of range gives zero
    function automatic lor_ana_t pick_ana(input logic [7:0] sel, input lor_ana_t [`LOR_NUM_STEPS-1:0] steps);
        lor_ana_t r;
        r = 16'h0000;
        if (sel != 8'h00 && sel <= 8'(`LOR_NUM_STEPS)) begin
            r = steps[sel - 8'h01];                        // Zero when disabled [RULE13]
        end
        return r;
    endfunction

    // Picks a routed digital output by terminal assignment 1..10
    function automatic logic pick_route(input logic [3:0] sel, input logic [`LOR_NUM_OUT-1:0] r);
        logic v;
        v = 1'b0;
        if (sel != 4'h0 && sel <= 4'(`LOR_NUM_OUT)) begin
            v = r[sel - 4'h1];
        end
        return v;
    endfunction

    // Register read decode; unmapped offsets read zero
    function automatic logic [31:0] reg_read(input lor_state_t s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        for (int i = 0; i < `LOR_NUM_OUT; i++) begin
            if (a == `LOR_SRC_BASE + 8'(4 * i)) begin
                d = {24'h00_0000, s.src[i]};
            end
            if (a == `LOR_FUNC_BASE + 8'(4 * i)) begin
                d = {16'h0000, s.func[i]};
            end
        end
        for (int k = 0; k < `LOR_NUM_DTERM; k++) begin
            if (a == `LOR_DTERM_BASE + 8'(4 * k)) begin
                d = {28'h000_0000, s.dterm_sel[k]};
            end
        end
        if (a == `LOR_ATERM_OFS) begin
            d = {28'h000_0000, s.aterm_sel};
        end
        if (a == `LOR_FEED_OFS) begin
            d = {24'h00_0000, s.feed_sel};
        end
        if (a == `LOR_STATUS_OFS) begin
            d = {19'h0_0000, s.dterm, s.route_dig};        // Live routed and terminal state
        end
        return d;
    endfunction

    // Next-state logic: bus slave, routing, binding and terminal refresh
    always_comb begin
        logic                  acc;
        logic                  hit;
        logic [`LOR_NUM_OUT-1:0] rt_dig;
        lor_ana_t [`LOR_NUM_OUT-1:0] rt_ana;
        logic [15:0]           f;
        logic                  tick;
        acc    = 1'b0;
        hit    = 1'b0;
        rt_dig = '0;
        rt_ana = '0;
        f      = 16'h0000;
        tick   = 1'b0;
        nxt_st = st_ff;
        nxt_st.hready = 1'b1;
        nxt_st.hresp  = 1'b0;

        // Write data phase: commit i_hwdata to the offset latched in the address phase
        if (st_ff.wr_pend) begin
            for (int i = 0; i < `LOR_NUM_OUT; i++) begin
                if (st_ff.wr_addr == `LOR_SRC_BASE + 8'(4 * i)) begin
                    nxt_st.src[i] = i_hwdata[7:0];
                end
                if (st_ff.wr_addr == `LOR_FUNC_BASE + 8'(4 * i)) begin
                    nxt_st.func[i] = i_hwdata[15:0];
                end
            end
            for (int k = 0; k < `LOR_NUM_DTERM; k++) begin
                if (st_ff.wr_addr == `LOR_DTERM_BASE + 8'(4 * k)) begin
                    nxt_st.dterm_sel[k] = i_hwdata[3:0];
                end
            end
            if (st_ff.wr_addr == `LOR_ATERM_OFS) begin
                nxt_st.aterm_sel = i_hwdata[3:0];
            end
            if (st_ff.wr_addr == `LOR_FEED_OFS) begin
                nxt_st.feed_sel = i_hwdata[7:0];
            end
        end

        // Address phase: decode, latch writes, fetch reads with write bypass
        acc = i_hsel && i_htrans[1] && i_hready;
        hit = (i_haddr[31:8] == 24'h00_0000);
        nxt_st.wr_pend = acc && i_hwrite && hit;
        nxt_st.wr_addr = i_haddr[7:0];
        if (acc && !i_hwrite && hit) begin
            nxt_st.hrdata = reg_read(nxt_st, i_haddr[7:0]);
        end else begin
            nxt_st.hrdata = 32'h0000_0000;
        end

        // Routing: each selector picks one numbered step result [RULE4]
        for (int i = 0; i < `LOR_NUM_OUT; i++) begin
            rt_dig[i] = pick_dig(st_ff.src[i], i_step_dig);
            rt_ana[i] = pick_ana(st_ff.src[i], i_step_ana);
        end
        nxt_st.route_dig = rt_dig;
        nxt_st.route_ana = rt_ana;

        // Feedback path for step inputs inside the logic engine [RULE3]
        nxt_st.feed_dig = pick_dig(st_ff.feed_sel, i_step_dig);
        nxt_st.feed_ana = pick_ana(st_ff.feed_sel, i_step_ana);

        // Binding: outside functions see only routed outputs [RULE2]
        nxt_st.seq_func = '0;
        nxt_st.cmd      = '0;
        for (int i = 0; i < `LOR_NUM_OUT; i++) begin
            f = st_ff.func[i];
            if (f < `LOR_DIG_NONE) begin
                // Positive logic sequence input [RULE8]
                nxt_st.seq_func[f[6:0]] = nxt_st.seq_func[f[6:0]] | rt_dig[i];
            end else if (f >= `LOR_DIG_NEG_BASE && f < `LOR_DIG_NEG_END) begin
                // Negative logic code; disabled output stays inactive [RULE5] [RULE13]
                nxt_st.seq_func[7'(f - `LOR_DIG_NEG_BASE)] =
                    nxt_st.seq_func[7'(f - `LOR_DIG_NEG_BASE)] | ((st_ff.src[i] != 8'h00) & ~rt_dig[i]);
            end else if (f == `LOR_ANA_SPEED) begin
                // Non-reversible: negative values clamp to zero [RULE6] [RULE9]
                nxt_st.cmd.speed = rt_ana[i][15] ? 16'h0000 : rt_ana[i];
            end else if (f == `LOR_ANA_SPEED_REV) begin
                nxt_st.cmd.speed_rev = rt_ana[i];          // Polarity sets direction [RULE6] [RULE9]
            end else if (f == `LOR_ANA_TORQUE) begin
                nxt_st.cmd.torque = rt_ana[i];             // Torque bias [RULE6] [RULE9]
            end
        end

        // Terminal refresh: sample once per tick, hold otherwise [RULE12] [RULE14]
        tick = (st_ff.tick_cnt == 20'(REFRESH_CYCLES - 1));
        if (tick) begin
            nxt_st.tick_cnt = 20'h0_0000;
            for (int k = 0; k < `LOR_NUM_DTERM; k++) begin
                nxt_st.dterm[k] = pick_route(st_ff.dterm_sel[k], st_ff.route_dig);  // [RULE10]
            end
        end else begin
            nxt_st.tick_cnt = st_ff.tick_cnt + 20'h0_0001;
        end

        // Analog terminal follows the routed output it names [RULE11]
        nxt_st.aterm = 16'h0000;
        if (st_ff.aterm_sel != 4'h0 && st_ff.aterm_sel <= 4'(`LOR_NUM_OUT)) begin
            nxt_st.aterm = st_ff.route_ana[st_ff.aterm_sel - 4'h1];
        end
    end

    // State register with synchronous reset to the defaults
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_ff        <= '0;
            st_ff.func   <= {`LOR_NUM_OUT{`LOR_FUNC_RST}};  // [RULE7]
            st_ff.hready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign o_hreadyout = st_ff.hready;
    assign o_hresp     = st_ff.hresp;
    assign o_hrdata    = st_ff.hrdata;
    assign o_route_dig = st_ff.route_dig;
    assign o_route_ana = st_ff.route_ana;
    assign o_seq_func  = st_ff.seq_func;
    assign o_cmd       = st_ff.cmd;
    assign o_dterm     = st_ff.dterm;
    assign o_aterm     = st_ff.aterm;
    assign o_feed_dig  = st_ff.feed_dig;
    assign o_feed_ana  = st_ff.feed_ana;

    // Helper values for the checks below
    logic       exp_dig0;                                  // Expected route 0 digital
    lor_ana_t   exp_ana9;                                  // Expected route 9 analog
    logic       exp_feed;                                  // Expected feedback digital
    logic       exp_term0;                                 // Expected terminal 0 sample
    logic [6:0] fcode0;                                    // Function code of route 0
    logic       tick_now;                                  // Refresh tick this cycle
    assign exp_dig0  = pick_dig(st_ff.src[0], i_step_dig);
    assign exp_ana9  = pick_ana(st_ff.src[9], i_step_ana);
    assign exp_feed  = pick_dig(st_ff.feed_sel, i_step_dig);
    assign exp_term0 = pick_route(st_ff.dterm_sel[0], st_ff.route_dig);
    assign fcode0    = st_ff.func[0][6:0];
    assign tick_now  = (st_ff.tick_cnt == 20'(REFRESH_CYCLES - 1));

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // Route 0 follows the step named by its selector
    a_route_pick_dig: assert property (1'b1 |=> o_route_dig[0] == $past(exp_dig0))  // [RULE1]
        else $error("routed output 0 does not match selected step");
    // Disabled selector drives zero both ways
    a_disabled_out_zero: assert property ((st_ff.src[0] == 8'h00) |=>  // [RULE13]
        (o_route_dig[0] == 1'b0 && o_route_ana[0] == 16'h0000))
        else $error("disabled routed output not zero");
    // Write to source 0 lands one cycle after its data phase
    a_src_write_lands: assert property (st_ff.wr_pend && st_ff.wr_addr == `LOR_SRC_BASE |=>  // [RULE4]
        st_ff.src[0] == $past(i_hwdata[7:0]))
        else $error("source selector write lost");
    // Function selectors come out of reset at their default
    a_func_reset_val: assert property ($past(i_rstn) == 1'b0 |->  // [RULE7]
        (st_ff.func[0] == `LOR_FUNC_RST && st_ff.func[9] == `LOR_FUNC_RST))
        else $error("function selector reset value wrong");
    // Positive code raises its sequence input
    a_seq_pos_bind: assert property ((st_ff.func[0] < `LOR_DIG_NONE && exp_dig0) |=>  // [RULE8]
        o_seq_func[$past(fcode0)])
        else $error("sequence input not driven by routed output");
    // Second negative code raises its input while the routed level is low
    a_seq_neg_bind: assert property  // [RULE5]
        ((st_ff.func[0] == `LOR_DIG_NEG_BASE + 16'h0001) && st_ff.src[0] != 8'h00 && !exp_dig0 |=> o_seq_func[1])
        else $error("negative logic binding wrong");
    // Torque bias follows the last routed output bound to it
    a_torque_bind: assert property ((st_ff.func[9] == `LOR_ANA_TORQUE) |=> o_cmd.torque == $past(exp_ana9))  // [RULE9]
        else $error("torque bias not from routed output");
    // Non-reversible speed never goes negative
    a_speed_nonneg: assert property ((st_ff.func[9] == `LOR_ANA_SPEED && exp_ana9[15]) |=>  // [RULE6]
        o_cmd.speed == 16'h0000)
        else $error("non-reversible speed took negative value");
    // Terminals hold between ticks
    a_term_hold: assert property (!tick_now |=> $stable(o_dterm))  // [RULE12]
        else $error("digital terminal changed between ticks");
    // Terminal samples its routed output on the tick
    a_term_sample: assert property (tick_now |=>  // [RULE14]
        (o_dterm[0] == $past(exp_term0) && st_ff.tick_cnt == 20'h0_0000))
        else $error("digital terminal missed its sample");
    // Analog terminal follows routed output 10
    a_aterm_follow: assert property ((st_ff.aterm_sel == 4'ha) |=> o_aterm == $past(st_ff.route_ana[9]))  // [RULE11]
        else $error("analog terminal not following routed output");
    // Feedback selector picks any step
    a_feed_pick: assert property (1'b1 |=> o_feed_dig == $past(exp_feed))  // [RULE3]
        else $error("feedback selector wrong");

    c_neg_bind: cover property (st_ff.func[0] == `LOR_DIG_NEG_BASE && st_ff.src[0] != 8'h00);
    c_torque: cover property (st_ff.func[9] == `LOR_ANA_TORQUE && exp_ana9 != 16'h0000);
    c_term_rise: cover property (tick_now ##1 $rose(o_dterm[0]));
    c_last_step: cover property (st_ff.src[0] == 8'(`LOR_NUM_STEPS));
endmodule

// >>> verification/lor_term_model.sv
// Purpose: Model of the terminal output stage fed by the router
// Assumes: Terminal levels may move only on refresh ticks
// Notes:   Flags a change whose spacing is off the tick grid
`timescale 1ns/10ps
module lor_term_model #(
    parameter int PERIOD = 16                  // Refresh period in cycles
) (
    input  wire logic       i_clk,             // Scan clock
    input  wire logic       i_rstn,            // Sync reset, active low
    input  wire logic [2:0] i_dterm,           // Terminal levels seen
    output logic            o_bad,             // Change off the tick grid
    output logic [7:0]      o_moves            // Count of level changes
);
    logic [2:0] last_ff;                       // Levels at the previous edge
    int         gap_ff;                        // Edges since the last change
    // Watch terminal changes and check their spacing
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            last_ff <= 3'h0;
            gap_ff  <= 0;
            o_bad   <= 1'b0;
            o_moves <= 8'h00;
        end else if (i_dterm != last_ff) begin
            // Spacing must be whole refresh periods
            if (o_moves != 8'h00 && (gap_ff + 1) % PERIOD != 0) begin
                o_bad <= 1'b1;
            end
            last_ff <= i_dterm;
            gap_ff  <= 0;
            o_moves <= o_moves + 8'h01;
        end else begin
            gap_ff <= gap_ff + 1;
        end
    end
endmodule

// >>> verification/testbench.sv
// Purpose: Self-checking bench of the logic output router
// Assumes: Short refresh period, zero-wait AHB-Lite slave
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/10ps
module testbench;
    import lor_pkg::*;
    localparam int PER = 16;                   // Short refresh period
    logic               i_clk = 1'b0;          // Scan clock
    logic               i_rstn = 1'b0;         // Reset, active low
    logic               hsel = 1'b0;           // Bus select
    logic [31:0]        haddr = 32'h0;         // Bus address
    logic [1:0]         htrans = 2'h0;         // Transfer type
    logic               hwrite = 1'b0;         // Write flag
    logic [31:0]        hwdata = 32'h0;        // Write data
    logic               hrdy, hresp, rdy_s;    // Ready, response, sampled ready
    logic [31:0]        hrdata, rd_s, q;       // Read data, sampled, result
    logic [199:0]       step_dig = '0;         // Digital step results
    lor_ana_t [199:0]   step_ana = '0;         // Analog step results
    logic [9:0]         route_dig;             // Routed digital outputs
    lor_ana_t [9:0]     route_ana;             // Routed analog outputs
    logic [99:0]        seq;                   // Sequence input functions
    lor_cmd_t           cmd;                   // Analog commands
    logic [2:0]         dterm;                 // Digital terminals
    lor_ana_t           aterm, feed_ana;       // Analog terminal, feedback
    logic               feed_dig, bad;         // Feedback bit, spacing flag
    logic [7:0]         moves;                 // Terminal changes seen
    int                 fails = 0;             // Mismatch count
    int                 comparisons = 0;       // Comparison count
    int                 cyc = 0;               // Cycle count for timeout

    lor_router #(.REFRESH_CYCLES(PER)) u_lor_router (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
        .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .i_step_dig(step_dig),
        .i_step_ana(step_ana), .o_route_dig(route_dig), .o_route_ana(route_ana), .o_seq_func(seq),
        .o_cmd(cmd), .o_dterm(dterm), .o_aterm(aterm), .o_feed_dig(feed_dig), .o_feed_ana(feed_ana));
    lor_term_model #(.PERIOD(PER)) u_lor_term_model (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_dterm(dterm), .o_bad(bad), .o_moves(moves));

    // Clock of 8 ns period
    always #4 i_clk = ~i_clk;
    // Capture what stands before each rising edge
    always @(negedge i_clk) begin
        rdy_s <= hrdy;
        rd_s  <= hrdata;
    end
    // Cut a hang short
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails = fails + 1;
            final_report();
        end
    end

    // Verdict and end of run
    task automatic final_report();
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Compare a bus read
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Compare a port value
    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One single AHB-Lite word transfer; returns at the data-phase edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge i_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge i_clk); while (rdy_s !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk); while (rdy_s !== 1'b1);
        r = rd_s;
    endtask
    // Let n edges pass, then stop where outputs are settled
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    // Reset values, read-back with upper bits dropped, unmapped place
    task automatic t_regs();
        for (int k = 0; k < 10; k++) begin
            xfer(1'b0, 32'(4 * k), 32'h0, q);
            chk_rd(q, 32'h0);
            xfer(1'b0, 32'(8'h28 + 4 * k), 32'h0, q);
            chk_rd(q, 32'h64);
            xfer(1'b1, 32'(4 * k), 32'hffff_ffc8, q);
            xfer(1'b0, 32'(4 * k), 32'h0, q);
            chk_rd(q, 32'hc8);
            xfer(1'b1, 32'(4 * k), 32'h0, q);
        end
        xfer(1'b1, 32'h80, 32'h5, q);
        xfer(1'b0, 32'h80, 32'h0, q);
        chk_rd(q, 32'h0);
    endtask
    // Last step routed, digital codes in both logic senses, disable
    task automatic t_dig();
        xfer(1'b1, 32'h0, 32'hc8, q);
        step_dig <= {1'b1, 199'h0};
        xfer(1'b1, 32'h28, 32'h1, q);
        settle(2);
        chk_out(16'(route_dig), 16'h1);
        chk_out(16'(seq[1:0]), 16'h2);
        xfer(1'b1, 32'h28, 32'h3e8, q);
        settle(2);
        chk_out(16'(seq[1:0]), 16'h0);
        xfer(1'b1, 32'h28, 32'h3e9, q);
        step_dig <= 200'h0;
        settle(2);
        chk_out(16'(seq[1:0]), 16'h2);
        xfer(1'b1, 32'h0, 32'h0, q);
        settle(2);
        chk_out(16'(|seq), 16'h0);
    endtask
    // Analog command codes
    task automatic t_ana();
        xfer(1'b1, 32'h24, 32'h5, q);
        step_ana[4] <= 16'h1234;
        xfer(1'b1, 32'h4c, 32'h1f42, q);
        settle(2);
        chk_out(cmd.speed_rev, 16'h1234);
        chk_out(route_ana[9], 16'h1234);
        xfer(1'b1, 32'h4c, 32'h1f41, q);
        settle(2);
        chk_out(cmd.speed, 16'h1234);
        @(posedge i_clk);
        step_ana[4] <= 16'hff00;
        settle(2);
        chk_out(cmd.speed, 16'h0);
        xfer(1'b1, 32'h4c, 32'h1f44, q);
        settle(2);
        chk_out(cmd.torque, 16'hff00);
    endtask
    // Terminals, status word, and holding between refresh ticks
    task automatic t_term();
        xfer(1'b1, 32'h08, 32'h7, q);
        step_dig <= 200'h40;
        xfer(1'b1, 32'h50, 32'h3, q);
        xfer(1'b1, 32'h5c, 32'ha, q);
        settle(2 * PER + 4);
        chk_out(16'(dterm), 16'h1);
        chk_out(aterm, 16'hff00);
        xfer(1'b0, 32'h64, 32'h0, q);
        chk_rd(q, 32'h404);
        for (int i = 0; i < 6 * PER; i++) begin
            @(posedge i_clk);
            if (i % 5 == 0) step_dig <= step_dig ^ 200'h40;
        end
        settle(1);
        chk_out(16'(bad), 16'h0);
        chk_out(16'(moves > 8'h2), 16'h1);
    endtask
    // Internal selector reaches the last step
    task automatic t_feed();
        xfer(1'b1, 32'h60, 32'hc8, q);
        step_dig <= {1'b1, 199'h0};
        step_ana[199] <= 16'h0abc;
        settle(2);
        chk_out(16'(feed_dig), 16'h1);
        chk_out(feed_ana, 16'h0abc);
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_regs();
        t_dig();
        t_ana();
        t_term();
        t_feed();
        final_report();
    end
endmodule
